// [irq_pkg.sv]
`default_nettype none
package irq_pkg;
   localparam int NUM_SRC = 13;
   localparam int SRC_W = 4;
   localparam int DATA_W = 16;
   localparam int ADDR_W = 4;
   localparam int PRIO_W = 4;
   localparam int TMR_W = 12;
   localparam int PRE_W = 3;
   localparam int PRE_CNT_W = 7;
   localparam int WDG_W = 16;

   // source index, lowest index wins a priority tie
   localparam int SRC_FILTERBANK = 0;
   localparam int SRC_AUDIO_FULL = 1;
   localparam int SRC_GEN_TIMER = 2;
   localparam int SRC_WATCHDOG = 3;
   localparam int SRC_SPI = 4;
   localparam int SRC_INFRARED = 5;
   localparam int SRC_EXT_RX = 6;
   localparam int SRC_EXT_TX = 7;
   localparam int SRC_GPIO = 8;
   localparam int SRC_TWO_WIRE = 9;
   localparam int SRC_UART_RX = 10;
   localparam int SRC_UART_TX = 11;
   localparam int SRC_PCM = 12;

   localparam logic [ADDR_W-1:0] ADR_IRQ_STATUS = 4'h0;
   localparam logic [ADDR_W-1:0] ADR_IRQ_MASK = 4'h1;
   localparam logic [ADDR_W-1:0] ADR_IRQ_VECTOR = 4'h2;
   localparam logic [ADDR_W-1:0] ADR_IRQ_ACK = 4'h3;
   localparam logic [ADDR_W-1:0] ADR_IRQ_PRIO0 = 4'h4;
   localparam logic [ADDR_W-1:0] ADR_TMR_CTRL = 4'h8;
   localparam logic [ADDR_W-1:0] ADR_TMR_RELOAD = 4'h9;
   localparam logic [ADDR_W-1:0] ADR_TMR_COUNT = 4'hA;
   localparam logic [ADDR_W-1:0] ADR_WDG_TIMEOUT = 4'hB;
   localparam logic [ADDR_W-1:0] ADR_WDG_ACK = 4'hC;
   localparam logic [ADDR_W-1:0] ADR_WDG_COUNT = 4'hD;

   // timer control fields
   localparam int TMR_START_BIT = 0;
   localparam int TMR_CONT_BIT = 1;
   localparam int TMR_PRE_LSB = 2;

   localparam logic [NUM_SRC-1:0] MASK_RST = 13'h0000;
   localparam logic [PRIO_W-1:0] PRIO_RST = 4'h0;
   localparam logic [TMR_W-1:0] TMR_RELOAD_RST = 12'hFFF;
   localparam logic [DATA_W-1:0] VEC_BASE = 16'h0100;
   localparam logic [DATA_W-1:0] VEC_STRIDE = 16'h0002;
endpackage
`default_nettype wire

// [interrupt_timer_watchdog.sv]
// Operation
// R1 - merge sources onto one prioritised interrupt line
// R2 - each source has its own vector
// R3 - software sets per-source priority levels
// R4 - acknowledge flag kept per source
// R5 - thirteen named peripheral sources
// R6 - filterbank completion raises its own interrupt
// R7 - 12-bit down-counter behind 3-bit prescaler
// R8 - single-shot: one interrupt then stop
// R9 - continuous: reload and interrupt every zero
// R10 - watchdog counts system clock, programmable timeout
// R11 - watchdog always on, software must acknowledge
// R12 - first watchdog timeout raises interrupt
// R13 - second consecutive timeout resets device
// R14 - acknowledge clears pending, new assertion resets it
// R15 - reload, prescale, mode writable; start loads
`default_nettype none
module interrupt_timer_watchdog
   import irq_pkg::*;
#(
   parameter logic [WDG_W-1:0] WDG_TIMEOUT_DEFAULT = 16'hFFFF
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata,
   input wire logic filterbank_done_irq,
   input wire logic audio_block_full_irq,
   input wire logic spi_irq,
   input wire logic infrared_remote_irq,
   input wire logic ext_reg_receive_irq,
   input wire logic ext_reg_transmit_irq,
   input wire logic gpio_irq,
   input wire logic two_wire_serial_irq,
   input wire logic uart_receive_irq,
   input wire logic uart_transmit_irq,
   input wire logic pcm_irq,
   input wire logic irq_ack,
   output logic irq_req,
   output logic [DATA_W-1:0] irq_vector,
   output logic [SRC_W-1:0] irq_src,
   output logic device_reset_req
);

   ////////////////////////////////////////////////////////////////////////
   // register decode

   wire logic wr_status = reg_wr && (reg_addr == ADR_IRQ_STATUS);
   wire logic wr_mask = reg_wr && (reg_addr == ADR_IRQ_MASK);
   wire logic wr_ack = reg_wr && (reg_addr == ADR_IRQ_ACK);
   wire logic wr_tmr_ctrl = reg_wr && (reg_addr == ADR_TMR_CTRL);
   wire logic wr_tmr_reload = reg_wr && (reg_addr == ADR_TMR_RELOAD);
   wire logic wr_wdg_timeout = reg_wr && (reg_addr == ADR_WDG_TIMEOUT);
   wire logic wr_wdg_ack = reg_wr && (reg_addr == ADR_WDG_ACK);
   wire logic rd_status = reg_rd && (reg_addr == ADR_IRQ_STATUS);
   wire logic wr_prio_any = reg_wr && (reg_addr[3:2] == ADR_IRQ_PRIO0[3:2]);

   ////////////////////////////////////////////////////////////////////////
   // general timer

   logic [TMR_W-1:0] tmr_reload_q;
   logic [TMR_W-1:0] tmr_count_q;
   logic [PRE_W-1:0] tmr_pre_sel_q;
   logic [PRE_CNT_W-1:0] pre_cnt_q;
   logic tmr_cont_q;
   logic tmr_run_q;
   logic tmr_fire_q;

   // divide by 2**sel, one-cycle enable
   wire logic [PRE_CNT_W-1:0] pre_top =
      PRE_CNT_W'((8'h01 << tmr_pre_sel_q) - 8'h01); // see R7
   wire logic pre_tick = tmr_run_q && (pre_cnt_q == pre_top); // see R7
   wire logic tmr_at_zero = (tmr_count_q == '0);
   wire logic tmr_start = wr_tmr_ctrl && reg_wdata[TMR_START_BIT];

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         tmr_reload_q <= TMR_RELOAD_RST;
         tmr_pre_sel_q <= '0;
         tmr_cont_q <= 1'b0;
      end else begin
         if (wr_tmr_reload) begin
            tmr_reload_q <= reg_wdata[TMR_W-1:0]; // see R15
         end
         if (wr_tmr_ctrl) begin
            tmr_pre_sel_q <= reg_wdata[TMR_PRE_LSB +: PRE_W]; // see R15
            tmr_cont_q <= reg_wdata[TMR_CONT_BIT]; // see R15
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         pre_cnt_q <= '0;
      end else if (tmr_start || pre_tick || !tmr_run_q) begin
         pre_cnt_q <= '0;
      end else begin
         pre_cnt_q <= pre_cnt_q + 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         tmr_count_q <= '0;
         tmr_run_q <= 1'b0;
         tmr_fire_q <= 1'b0;
      end else begin
         tmr_fire_q <= 1'b0;
         if (wr_tmr_ctrl) begin
            tmr_run_q <= reg_wdata[TMR_START_BIT];
            if (tmr_start) begin
               tmr_count_q <= tmr_reload_q; // see R15
            end
         end else if (pre_tick) begin
            if (tmr_at_zero) begin
               tmr_fire_q <= 1'b1; // see R7
               if (tmr_cont_q) begin
                  tmr_count_q <= tmr_reload_q; // see R9
               end else begin
                  tmr_run_q <= 1'b0; // see R8
               end
            end else begin
               tmr_count_q <= tmr_count_q - 1'b1; // see R7
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // watchdog, no enable bit exists

   logic [WDG_W-1:0] wdg_timeout_q;
   logic [WDG_W-1:0] wdg_count_q;
   logic wdg_armed_q;
   logic wdg_fire_q;

   wire logic wdg_expire = (wdg_count_q >= wdg_timeout_q); // see R10

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         wdg_timeout_q <= WDG_TIMEOUT_DEFAULT;
         wdg_count_q <= '0;
         wdg_armed_q <= 1'b0;
         wdg_fire_q <= 1'b0;
         device_reset_req <= 1'b0;
      end else begin
         wdg_fire_q <= 1'b0;
         device_reset_req <= 1'b0;
         if (wr_wdg_timeout) begin
            wdg_timeout_q <= reg_wdata[WDG_W-1:0]; // see R10
         end
         if (wr_wdg_ack) begin
            wdg_count_q <= '0; // see R11
            wdg_armed_q <= 1'b0; // see R11
         end else if (wdg_expire) begin
            wdg_count_q <= '0;
            if (wdg_armed_q) begin
               device_reset_req <= 1'b1; // see R13
               wdg_armed_q <= 1'b0;
            end else begin
               wdg_fire_q <= 1'b1; // see R12
               wdg_armed_q <= 1'b1;
            end
         end else begin
            wdg_count_q <= wdg_count_q + 1'b1; // see R10
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // source collection and pending flags

   logic [NUM_SRC-1:0] src_lvl;
   logic [NUM_SRC-1:0] src_lvl_q;
   logic [NUM_SRC-1:0] pend_q;
   logic [NUM_SRC-1:0] mask_q;
   logic [PRIO_W-1:0] prio_q [NUM_SRC];

   always_comb begin
      src_lvl = '0;
      src_lvl[SRC_FILTERBANK] = filterbank_done_irq; // see R6
      src_lvl[SRC_AUDIO_FULL] = audio_block_full_irq; // see R5
      src_lvl[SRC_GEN_TIMER] = tmr_fire_q; // see R5
      src_lvl[SRC_WATCHDOG] = wdg_fire_q; // see R5
      src_lvl[SRC_SPI] = spi_irq;
      src_lvl[SRC_INFRARED] = infrared_remote_irq;
      src_lvl[SRC_EXT_RX] = ext_reg_receive_irq;
      src_lvl[SRC_EXT_TX] = ext_reg_transmit_irq;
      src_lvl[SRC_GPIO] = gpio_irq;
      src_lvl[SRC_TWO_WIRE] = two_wire_serial_irq;
      src_lvl[SRC_UART_RX] = uart_receive_irq;
      src_lvl[SRC_UART_TX] = uart_transmit_irq;
      src_lvl[SRC_PCM] = pcm_irq;
   end

   // rising edges only, so a held level does not re-pend after ack
   wire logic [NUM_SRC-1:0] src_set = src_lvl & ~src_lvl_q; // see R14

   wire logic [NUM_SRC-1:0] ack_core = irq_ack ?
      (NUM_SRC'(1) << irq_src) : '0; // see R4
   wire logic [NUM_SRC-1:0] ack_reg = wr_ack ?
      (NUM_SRC'(1) << reg_wdata[SRC_W-1:0]) : '0; // see R4
   wire logic [NUM_SRC-1:0] clr_status =
      (rd_status ? pend_q : '0) | (wr_status ? reg_wdata[NUM_SRC-1:0] : '0);
   wire logic [NUM_SRC-1:0] pend_clr = ack_core | ack_reg | clr_status;

   // set beats a clear landing in the same cycle
   wire logic [NUM_SRC-1:0] pend_d = (pend_q & ~pend_clr) | src_set; // see R14

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         src_lvl_q <= '0;
         pend_q <= '0;
         mask_q <= MASK_RST;
      end else begin
         src_lvl_q <= src_lvl;
         pend_q <= pend_d; // see R4
         if (wr_mask) begin
            mask_q <= reg_wdata[NUM_SRC-1:0];
         end
      end
   end

   // up to four 4-bit levels per priority register; the last holds source 12 alone
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < NUM_SRC; i++) begin
            prio_q[i] <= PRIO_RST;
         end
      end else if (wr_prio_any) begin
         for (int i = 0; i < NUM_SRC; i++) begin
            if (reg_addr[1:0] == 2'(i / 4)) begin
               prio_q[i] <= reg_wdata[(i % 4) * PRIO_W +: PRIO_W]; // see R3
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // arbitration: highest level wins, lowest index breaks ties

   // judged on the next pending set, so source and vector move with the request
   wire logic [NUM_SRC-1:0] active = pend_d & mask_q;
   logic [SRC_W-1:0] win_idx;
   logic [PRIO_W-1:0] win_lvl;
   logic win_found;

   always_comb begin
      win_idx = '0;
      win_lvl = '0;
      win_found = 1'b0;
      for (int i = 0; i < NUM_SRC; i++) begin
         if (active[i] && (!win_found || prio_q[i] > win_lvl)) begin // see R1
            win_idx = SRC_W'(i);
            win_lvl = prio_q[i];
            win_found = 1'b1;
         end
      end
   end

   wire logic [DATA_W-1:0] win_vector =
      VEC_BASE + DATA_W'(win_idx) * VEC_STRIDE; // see R2

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_req <= 1'b0;
         irq_src <= '0;
         irq_vector <= VEC_BASE;
      end else begin
         irq_req <= |active; // see R1
         irq_src <= win_idx;
         irq_vector <= win_vector; // see R2
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read port

   logic [DATA_W-1:0] rd_mux;

   always_comb begin
      rd_mux = '0;
      if (reg_addr == ADR_IRQ_STATUS) begin
         rd_mux = DATA_W'(pend_q);
      end else if (reg_addr == ADR_IRQ_MASK) begin
         rd_mux = DATA_W'(mask_q);
      end else if (reg_addr == ADR_IRQ_VECTOR) begin
         rd_mux = win_vector;
      end else if (reg_addr[3:2] == ADR_IRQ_PRIO0[3:2]) begin
         for (int i = 0; i < NUM_SRC; i++) begin
            if (reg_addr[1:0] == 2'(i / 4)) begin
               rd_mux[(i % 4) * PRIO_W +: PRIO_W] = prio_q[i];
            end
         end
      end else if (reg_addr == ADR_TMR_CTRL) begin
         rd_mux = DATA_W'({tmr_pre_sel_q, tmr_cont_q, tmr_run_q});
      end else if (reg_addr == ADR_TMR_RELOAD) begin
         rd_mux = DATA_W'(tmr_reload_q);
      end else if (reg_addr == ADR_TMR_COUNT) begin
         rd_mux = DATA_W'(tmr_count_q);
      end else if (reg_addr == ADR_WDG_TIMEOUT) begin
         rd_mux = wdg_timeout_q;
      end else if (reg_addr == ADR_WDG_COUNT) begin
         rd_mux = DATA_W'({wdg_armed_q, 15'h0000}) | wdg_count_q;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         reg_rdata <= rd_mux;
      end else begin
         reg_rdata <= '0;
      end
   end

endmodule // interrupt_timer_watchdog
`default_nettype wire

// [itw_sva.sv]
`default_nettype none
module itw_sva
   import irq_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [DATA_W-1:0] reg_rdata,
   input wire logic spi_irq,
   input wire logic irq_ack,
   input wire logic irq_req,
   input wire logic [DATA_W-1:0] irq_vector,
   input wire logic [SRC_W-1:0] irq_src,
   input wire logic device_reset_req
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
      else $error("read data outside its slot");
   a_unmapped_zero: assert property (reg_rd && reg_addr == 4'hF |=> reg_rdata == '0)
      else $error("unmapped read not zero");
   a_vector_map: assert property (irq_vector == VEC_BASE + VEC_STRIDE * 16'(irq_src))
      else $error("vector does not match source");
   a_src_range: assert property (irq_src <= 4'hC)
      else $error("source index out of range");
   a_req_holds: assert property (irq_req && !irq_ack && !reg_wr && !reg_rd |=> irq_req)
      else $error("request dropped without clear");
   a_ack_clears: assert property (irq_ack && irq_req && irq_src == 4'h4 && !spi_irq
      && !$past(spi_irq) |=> !irq_req || irq_src != 4'h4)
      else $error("acknowledge left source pending");
   a_reset_pulse: assert property (device_reset_req |=> !device_reset_req)
      else $error("reset request longer than one cycle");
   a_wdg_ack_quiet: assert property (reg_wr && reg_addr == ADR_WDG_ACK
      |=> ##1 !device_reset_req [*8])
      else $error("reset right after watchdog acknowledge");
endmodule // itw_sva
bind interrupt_timer_watchdog itw_sva u_sva (.core_clk, .rst_b, .reg_addr, .reg_wr, .reg_rd,
   .reg_rdata, .spi_irq, .irq_ack, .irq_req, .irq_vector, .irq_src, .device_reset_req);
`default_nettype wire

// [core_model.sv]
`default_nettype none
module core_model
(
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic irq_req,
   input wire logic ack_en,
   input wire logic [2:0] ack_delay,
   output logic irq_ack
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] wait_q;
   // one acknowledge per request, then a cycle for the request to settle
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         wait_q <= '0;
         irq_ack <= 1'b0;
      end else begin
         irq_ack <= 1'b0;
         if (irq_ack || !irq_req || !ack_en) begin
            wait_q <= '0;
         end else if (wait_q >= {1'b0, ack_delay}) begin
            irq_ack <= 1'b1;
            wait_q <= '0;
         end else begin
            wait_q <= wait_q + 4'h1;
         end
      end
   end
endmodule // core_model
`default_nettype wire

// [interrupt_timer_watchdog_tb_top.sv]
`default_nettype none
module interrupt_timer_watchdog_tb_top
   import irq_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, ack_en = 0, rd_seen = 0;
   logic irq_ack, irq_req, device_reset_req;
   logic [ADDR_W-1:0] reg_addr = '0;
   logic [DATA_W-1:0] reg_wdata = '0, reg_rdata, irq_vector;
   logic [SRC_W-1:0] irq_src, e;
   logic [NUM_SRC-1:0] src = '0;
   logic [2:0] ack_delay = '0;
   logic [31:0] seed = 32'hDA46;
   int miscompares = 0, compares = 0, cycles = 0, resets = 0, n;
   logic [DATA_W-1:0] rd_q[$];
   logic [SRC_W-1:0] ack_q[$];
   logic [ADDR_W-1:0] ra[5] =
      '{ADR_IRQ_MASK, ADR_IRQ_PRIO0, ADR_TMR_RELOAD, ADR_WDG_TIMEOUT, 4'hF};
   logic [DATA_W-1:0] rv[5] = '{16'h0000, 16'h0000, 16'h0FFF, 16'h4000, 16'h0000};
   interrupt_timer_watchdog #(.WDG_TIMEOUT_DEFAULT(16'h4000)) DUT (
      .core_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .filterbank_done_irq(src[0]), .audio_block_full_irq(src[1]), .spi_irq(src[4]),
      .infrared_remote_irq(src[5]), .ext_reg_receive_irq(src[6]),
      .ext_reg_transmit_irq(src[7]), .gpio_irq(src[8]), .two_wire_serial_irq(src[9]),
      .uart_receive_irq(src[10]), .uart_transmit_irq(src[11]), .pcm_irq(src[12]),
      .irq_ack, .irq_req, .irq_vector, .irq_src, .device_reset_req);
   core_model core (.core_clk, .rst_b, .irq_req, .ack_en, .ack_delay, .irq_ack);
   initial forever #25 core_clk = ~core_clk;
////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   task automatic chk(string w, logic [15:0] x, logic [15:0] g);
      compares++;
      if (g !== x) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", w, x, g);
      end
   endtask
   task automatic results;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic bus(logic w, logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= w;
      reg_rd <= !w;
      if (!w) rd_q.push_back(d);
      @(posedge core_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic cyc(int c);
      repeat (c) @(posedge core_clk);
   endtask
   task automatic drain;
      for (int k = 0; k < 200 && ack_q.size() > 0; k++) @(posedge core_clk);
      chk("acks_left", 0, 16'(ack_q.size()));
   endtask
////////////////////////////////////////////////////////////////////////////////
   always @(posedge core_clk) begin
      rd_seen <= reg_rd;
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         results();
      end
   end
   always @(negedge core_clk) begin
      if (rd_seen) chk("rdata", rd_q.pop_front(), reg_rdata);
      if (device_reset_req === 1'b1) resets++;
      if (irq_ack === 1'b1) begin
         e = ack_q.size() ? ack_q.pop_front() : 4'hF;
         chk("ack_src", 16'(e), 16'(irq_src));
         chk("ack_vec", VEC_BASE + VEC_STRIDE * 16'(e), irq_vector);
      end
   end
   initial begin
      cyc(20);
      rst_b <= 1'b1;
      foreach (ra[i]) bus(0, ra[i], rv[i]);
      src[SRC_GPIO] <= 1'b1;
      cyc(1);
      src[SRC_GPIO] <= 1'b0;
      cyc(1);
      bus(0, ADR_IRQ_STATUS, 16'h0100);
      bus(0, ADR_IRQ_STATUS, 16'h0000);
      @(negedge core_clk);
      chk("masked_req", 0, 16'(irq_req));
      cyc(1);
      bus(1, ADR_IRQ_MASK, 16'h1FF3);
      src <= 13'h1010;
      cyc(1);
      src <= '0;
      cyc(3);
      @(negedge core_clk);
      chk("tie_src", 4, 16'(irq_src));
      cyc(1);
      bus(1, ADR_IRQ_PRIO0 + 4'h3, 16'h0001);
      @(negedge core_clk);
      chk("prio_src", 12, 16'(irq_src));
      cyc(1);
      bus(0, ADR_IRQ_VECTOR, 16'h0118);
      ack_q.push_back(4'hC);
      ack_q.push_back(4'h4);
      ack_en <= 1'b1;
      drain();
      repeat (2) for (int i = 0; i < NUM_SRC; i++) if (i > SRC_WATCHDOG || i < SRC_GEN_TIMER) begin
         seed = xs(seed);
         ack_delay <= seed[2:0];
         ack_q.push_back(4'(i));
         src[i] <= 1'b1;
         drain();
         cyc(3);
         @(negedge core_clk);
         chk("held_req", 0, 16'(irq_req));
         cyc(1);
         src[i] <= 1'b0;
         cyc(1);
      end
      // random bursts of sources: pcm first by its level, the rest by index
      repeat (4) begin
         seed = xs(seed);
         ack_delay <= seed[15:13];
         src <= seed[12:0] & 13'h1FF3;
         if (seed[SRC_PCM]) ack_q.push_back(4'hC);
         for (int i = 0; i < SRC_PCM; i++) begin
            if (seed[i] && i != SRC_GEN_TIMER && i != SRC_WATCHDOG) begin
               ack_q.push_back(4'(i));
            end
         end
         cyc(1);
         src <= '0;
         drain();
      end
      bus(1, ADR_IRQ_MASK, 16'h0004);
      bus(1, ADR_TMR_RELOAD, 16'h0004);
      ack_q.push_back(4'h2);
      bus(1, ADR_TMR_CTRL, 16'h0009);
      n = 0;
      while (irq_req !== 1'b1 && n < 60) begin
         @(negedge core_clk);
         n++;
      end
      chk("tmr_period", 1, 16'(n >= 16 && n <= 26));
      cyc(100);
      drain();
      ack_delay <= 3'h0;
      bus(1, ADR_TMR_RELOAD, 16'h0009);
      repeat (3) ack_q.push_back(4'h2);
      bus(1, ADR_TMR_CTRL, 16'h0003);
      cyc(33);
      bus(1, ADR_TMR_CTRL, 16'h0000);
      cyc(20);
      drain();
      bus(1, ADR_WDG_ACK, 16'h0000);
      bus(1, ADR_WDG_TIMEOUT, 16'h0020);
      bus(1, ADR_IRQ_MASK, 16'h0008);
      repeat (6) begin
         cyc(16);
         bus(1, ADR_WDG_ACK, 16'h0000);
      end
      ack_q.push_back(4'h3);
      cyc(80);
      bus(1, ADR_WDG_ACK, 16'h0000);
      drain();
      chk("resets", 1, 16'(resets));
      results();
   end
endmodule // interrupt_timer_watchdog_tb_top
`default_nettype wire
